// ### hdl/hps_playback_seq.v
// Playback front end of a haptic driver: register file, waveform sequencer,
// real-time amplitude path, noise gate and supply reporting.
// Assumes a library ROM with one cycle of read latency on aclk and a drive
// core that runs calibration and diagnostics and reports their end.
//
// Overview of operation
// (RQ1) Library select bit picks the resonant or rotating-mass effect library.
// (RQ2) Time offsets touch library effects only, never real-time amplitudes.
// (RQ3) Four signed 8-bit offsets, default zero, are added to segment times.
// (RQ4) Most positive segment is overdrive, most negative segment is brake.
// (RQ5) Offsets apply to pairs and ramps; ramps interpolate over the new time.
// (RQ6) A library tick is 5 ms, or 1 ms with the interval bit set.
// (RQ7) Eight sequence slots hold waveform numbers or wait steps.
// (RQ8) Sequence starts at slot one, stops at a zero entry or after eight.
// (RQ9) Waveform numbers 1 to 127 index the library; zero ends the list.
// (RQ10) A slot with its top bit set waits its low seven bits times 10 ms.
// (RQ11) Each entry repeats by its own loop count before the next slot.
// (RQ12) Whole list replays main-loop count extra times, then standby.
// (RQ13) Real-time mode sends the 8-bit amplitude register to the drive.
// (RQ14) Real-time play lasts until a stop or a change of mode.
// (RQ15) Resonant drive tracks resonance unless open loop uses set period.
// (RQ16) Every process waits for a trigger from the launch bit or the pin.
// (RQ17) A process ends on its own completion or on a stop trigger.
// (RQ18) Drive levels below the noise gate threshold are suppressed.
// (RQ19) Supply voltage is captured each drive cycle into an 8-bit field.
// (RQ20) Shutdown pin low returns every register to its default.
// (RQ21) Writing zero to the launch bit stops the running process.
// (RQ22) A finished process returns to standby on its own.
// (RQ23) Wait steps drive zero, then move on when the time has run out.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "hps_defs.vh"
module hps_playback_seq #(
	parameter [17:0] MS_CYC = `HPS_MS_CYC
) (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write channels.
	input wire [7:0] awaddr,
	input wire awvalid,
	output wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	output wire [1:0] bresp,
	output wire bvalid,
	input wire bready,
	// AXI4-Lite read channels.
	input wire [7:0] araddr,
	input wire arvalid,
	output wire arready,
	output wire [31:0] rdata,
	output wire [1:0] rresp,
	output wire rvalid,
	input wire rready,
	// Device pins.
	input wire shutdown_pin_n,
	input wire trigger_interrupt_pin,
	// Effect library ROM.
	output wire [11:0] lib_addr,
	input wire [17:0] lib_data,
	// Drive core.
	output wire [7:0] drive_amp,
	output wire drive_en,
	output wire drive_from_lib,
	output wire drive_library_select_bit,
	output wire drive_open_loop,
	output wire [6:0] drive_ol_period,
	output wire [1:0] proc_mode,
	output wire proc_start,
	output wire proc_abort,
	input wire proc_done,
	input wire [7:0] vdd_sample,
	input wire vdd_strobe
);
	localparam S_IDLE = 4'h0;
	localparam S_ENTRY = 4'h1;
	localparam S_SCAN = 4'h2;
	localparam S_LOAD = 4'h3;
	localparam S_SEG = 4'h4;
	localparam S_WAIT = 4'h5;
	localparam S_RTP = 4'h6;
	localparam S_EXT = 4'h7;
	localparam S_NEXT = 4'h8;
	localparam [17:0] MS_LAST = MS_CYC - 18'h1;

	reg trig_s1_ff, trig_s2_ff, trig_d_ff, sd_s1_ff, sd_s2_ff;
	reg [7:0] aw_a_ff, ar_a_ff;
	reg aw_h_ff, w_h_ff, bvalid_ff, rvalid_ff, bad_w_ff;
	reg [1:0] rresp_ff;
	reg [31:0] w_d_ff, rdata_ff;
	reg [3:0] w_s_ff;
	reg [31:0] ctrl_ff, ofs_ff, seqa_ff, seqb_ff, loop_ff, rtp_ff;
	reg [7:0] vbat_ff;
	reg [3:0] st_ff;
	reg start_p_ff, pstart_ff, pabort_ff;
	reg [2:0] slot_ff, main_ff, div5_ff;
	reg [1:0] rep_ff;
	reg [6:0] id_ff;
	reg [3:0] seg_ff;
	reg ph_ff, ramp_ff, last_ff;
	reg signed [7:0] max_ff, min_ff, amp_ff, prev_ff, out_ff;
	reg [9:0] dur_ff, el_ff;
	reg [10:0] wait_ff;
	reg [17:0] ms_cnt_ff;
	reg ms_p_ff;
	reg [7:0] drv_ff;
	reg [31:0] rd_v;
	reg rd_ok;
	reg signed [7:0] raw_v, ofs_v;
	reg [7:0] mag_v, thr_v;

	// Shutdown low acts like a register reset once it has been synchronised.
	wire rst = ~aresetn | ~sd_s2_ff; // [RQ20]
	wire busy = (st_ff != S_IDLE);
	wire wr_fire = aw_h_ff & w_h_ff & ~bvalid_ff;
	wire ar_fire = arvalid & ~rvalid_ff;
	wire [31:0] seqs_lo = seqa_ff;
	wire [63:0] seqs = {seqb_ff, seqs_lo};
	wire [7:0] slot_v = seqs[{slot_ff, 3'h0} +: 8];
	wire [2:0] slot_n = slot_ff + 3'h1;
	wire [7:0] slot_nv = seqs[{slot_n, 3'h0} +: 8];
	wire [1:0] loop_n = loop_ff[{slot_n, 1'b0} +: 2];
	wire [1:0] mode = ctrl_ff[`HPS_MODE];
	wire signed [7:0] lib_amp = lib_data[7:0];
	wire [7:0] lib_tk = lib_data[15:8];
	wire pin_edge = trig_s2_ff & ~trig_d_ff & ctrl_ff[`HPS_TRIGEN];
	wire go_wr = wr_fire & (aw_a_ff == `HPS_A_CTRL) & w_s_ff[0];
	wire start_req = ~busy & ((go_wr & w_d_ff[`HPS_GO]) | pin_edge); // [RQ16]
	wire stop_req = busy & ((go_wr & ~w_d_ff[`HPS_GO]) | pin_edge); // [RQ21]
	wire tick = ms_p_ff & (ctrl_ff[`HPS_PBI] | (div5_ff == 3'h4)); // [RQ6]
	wire signed [9:0] dsum = $signed({2'b00, lib_tk}) + {{2{ofs_v[7]}}, ofs_v};
	wire dur_ok = ~dsum[9] & (dsum != 10'h000);
	wire signed [8:0] dlt = {amp_ff[7], amp_ff} - {prev_ff[7], prev_ff};
	wire signed [19:0] prod = dlt * $signed({1'b0, el_ff});
	wire signed [19:0] quo = prod / $signed({10'h000, dur_ff});
	wire signed [7:0] interp = prev_ff + quo[7:0]; // [RQ5]

	// Byte-lane merge for writes with partial strobes.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] d;
		input [3:0] s;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (s[i])
					merge[8*i +: 8] = d[8*i +: 8];
		end
	endfunction

	// Pin synchronisers; the edge detector reads only the second stage.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			trig_s1_ff <= 1'b0;
			trig_s2_ff <= 1'b0;
			trig_d_ff <= 1'b0;
			sd_s1_ff <= 1'b0;
			sd_s2_ff <= 1'b0;
		end
		else
		begin
			trig_s1_ff <= trigger_interrupt_pin;
			trig_s2_ff <= trig_s1_ff;
			trig_d_ff <= trig_s2_ff;
			sd_s1_ff <= shutdown_pin_n;
			sd_s2_ff <= sd_s1_ff;
		end
	end

	// Write channels are held independently so either may arrive first.
	always @(posedge aclk)
	begin
		if (rst)
		begin
			aw_h_ff <= 1'b0;
			w_h_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bad_w_ff <= 1'b0;
			aw_a_ff <= 8'h00;
			w_d_ff <= 32'h00000000;
			w_s_ff <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_h_ff <= 1'b1;
				aw_a_ff <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_h_ff <= 1'b1;
				w_d_ff <= wdata;
				w_s_ff <= wstrb;
			end
			if (wr_fire)
			begin
				aw_h_ff <= 1'b0;
				w_h_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bad_w_ff <= (aw_a_ff > `HPS_A_RTP) | (aw_a_ff[1:0] != 2'h0);
			end
			else if (bready)
				bvalid_ff <= 1'b0;
		end
	end

	assign awready = ~aw_h_ff & ~bvalid_ff;
	assign wready = ~w_h_ff & ~bvalid_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bad_w_ff ? 2'h2 : 2'h0;

	// Read decode; the launch bit reads back as the busy state.
	always @*
	begin
		rd_ok = 1'b1;
		case (araddr)
			`HPS_A_CTRL: rd_v = {ctrl_ff[31:1], busy};
			`HPS_A_STAT: rd_v = {16'h0000, vbat_ff, 3'h0, busy, st_ff}; // [RQ19]
			`HPS_A_OFS: rd_v = ofs_ff;
			`HPS_A_SEQA: rd_v = seqa_ff;
			`HPS_A_SEQB: rd_v = seqb_ff;
			`HPS_A_LOOP: rd_v = loop_ff;
			`HPS_A_RTP: rd_v = rtp_ff;
			default:
			begin
				rd_v = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end

	// Read channel: one cycle from address to data.
	always @(posedge aclk)
	begin
		if (rst)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= 2'h0;
		end
		else if (ar_fire)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_v;
			rresp_ff <= rd_ok ? 2'h0 : 2'h2;
		end
		else if (rready)
			rvalid_ff <= 1'b0;
	end

	assign arready = ~rvalid_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;

	// Register file; shutdown restores every default.
	always @(posedge aclk)
	begin
		if (rst)
		begin
			ctrl_ff <= `HPS_R_CTRL; // [RQ20]
			ofs_ff <= `HPS_R_OFS; // [RQ3]
			seqa_ff <= `HPS_R_SEQ;
			seqb_ff <= `HPS_R_SEQ;
			loop_ff <= `HPS_R_LOOP;
			rtp_ff <= `HPS_R_RTP;
			vbat_ff <= 8'h00;
		end
		else
		begin
			if (wr_fire)
				case (aw_a_ff)
					`HPS_A_CTRL: ctrl_ff <= merge(ctrl_ff, w_d_ff, w_s_ff) & 32'h0000007e;
					`HPS_A_OFS: ofs_ff <= merge(ofs_ff, w_d_ff, w_s_ff);
					`HPS_A_SEQA: seqa_ff <= merge(seqa_ff, w_d_ff, w_s_ff); // [RQ7]
					`HPS_A_SEQB: seqb_ff <= merge(seqb_ff, w_d_ff, w_s_ff);
					`HPS_A_LOOP: loop_ff <= merge(loop_ff, w_d_ff, w_s_ff) & 32'h0007ffff;
					`HPS_A_RTP: rtp_ff <= merge(rtp_ff, w_d_ff, w_s_ff) & 32'h007f03ff;
					default: ctrl_ff <= ctrl_ff;
				endcase
			// Only samples taken while the drive runs are kept.
			if (vdd_strobe && drive_en)
				vbat_ff <= vdd_sample; // [RQ19]
		end
	end

	// Segment role picks the offset: overdrive, brake or sustain.
	always @*
	begin
		if (lib_amp == max_ff && lib_amp > 8'sh00)
			ofs_v = ofs_ff[7:0]; // [RQ4]
		else if (lib_amp == min_ff && lib_amp < 8'sh00)
			ofs_v = ofs_ff[31:24]; // [RQ4]
		else if (lib_amp > 8'sh00)
			ofs_v = ofs_ff[15:8];
		else if (lib_amp < 8'sh00)
			ofs_v = ofs_ff[23:16];
		else
			ofs_v = 8'sh00;
	end

	// Millisecond base; it restarts at each launch so ticks line up.
	always @(posedge aclk)
	begin
		if (rst || start_p_ff || !busy)
		begin
			ms_cnt_ff <= 18'h00000;
			ms_p_ff <= 1'b0;
			div5_ff <= 3'h0;
		end
		else
		begin
			ms_p_ff <= (ms_cnt_ff == MS_LAST);
			ms_cnt_ff <= (ms_cnt_ff == MS_LAST) ? 18'h00000 : ms_cnt_ff + 18'h00001;
			if (ms_p_ff)
				div5_ff <= (div5_ff == 3'h4) ? 3'h0 : div5_ff + 3'h1; // [RQ6]
		end
	end

	// Main process state machine.
	always @(posedge aclk)
	begin
		if (rst)
		begin
			st_ff <= S_IDLE;
			start_p_ff <= 1'b0;
			pstart_ff <= 1'b0;
			pabort_ff <= 1'b0;
			slot_ff <= 3'h0;
			rep_ff <= 2'h0;
			main_ff <= 3'h0;
			id_ff <= 7'h00;
			seg_ff <= 4'h0;
			ph_ff <= 1'b0;
			ramp_ff <= 1'b0;
			last_ff <= 1'b0;
			max_ff <= 8'sh00;
			min_ff <= 8'sh00;
			amp_ff <= 8'sh00;
			prev_ff <= 8'sh00;
			dur_ff <= 10'h001;
			el_ff <= 10'h000;
			wait_ff <= 11'h000;
		end
		else
		begin
			// The launch takes effect a cycle later so a mode written with it applies.
			start_p_ff <= start_req;
			pstart_ff <= 1'b0;
			pabort_ff <= 1'b0;
			if (stop_req)
			begin
				st_ff <= S_IDLE; // [RQ17]
				pabort_ff <= (st_ff == S_EXT);
			end
			else
				case (st_ff)
					S_IDLE:
						if (start_p_ff)
						begin
							slot_ff <= 3'h0; // [RQ8]
							rep_ff <= loop_ff[1:0];
							main_ff <= loop_ff[`HPS_MAIN];
							if (mode == `HPS_M_SEQ)
								st_ff <= S_ENTRY;
							else if (mode == `HPS_M_RTP)
								st_ff <= S_RTP;
							else
							begin
								st_ff <= S_EXT; // [RQ16]
								pstart_ff <= 1'b1;
							end
						end
					S_ENTRY:
						if (slot_v == 8'h00)
							st_ff <= S_IDLE; // [RQ9]
						else if (slot_v[7])
						begin
							wait_ff <= {4'h0, slot_v[6:0]} * 11'h00a; // [RQ10]
							st_ff <= (slot_v[6:0] == 7'h00) ? S_NEXT : S_WAIT;
						end
						else
						begin
							id_ff <= slot_v[6:0]; // [RQ9]
							seg_ff <= 4'h0;
							ph_ff <= 1'b0;
							max_ff <= 8'sh00;
							min_ff <= 8'sh00;
							prev_ff <= 8'sh00;
							st_ff <= S_SCAN;
						end
					// First pass finds the peaks that mark overdrive and brake.
					S_SCAN:
						if (!ph_ff)
							ph_ff <= 1'b1;
						else
						begin
							ph_ff <= 1'b0;
							if (lib_amp > max_ff)
								max_ff <= lib_amp; // [RQ4]
							if (lib_amp < min_ff)
								min_ff <= lib_amp;
							seg_ff <= lib_data[17] ? 4'h0 : seg_ff + 4'h1;
							if (lib_data[17])
								st_ff <= S_LOAD;
						end
					S_LOAD:
						if (!ph_ff)
							ph_ff <= 1'b1;
						else
						begin
							ph_ff <= 1'b0;
							amp_ff <= lib_amp;
							ramp_ff <= lib_data[16];
							last_ff <= lib_data[17];
							el_ff <= 10'h000;
							dur_ff <= dsum; // [RQ3]
							if (dur_ok)
								st_ff <= S_SEG;
							else if (lib_data[17])
								st_ff <= S_NEXT;
							else
							begin
								prev_ff <= lib_amp;
								seg_ff <= seg_ff + 4'h1;
							end
						end
					S_SEG:
						if (tick)
						begin
							el_ff <= el_ff + 10'h001;
							if (el_ff + 10'h001 == dur_ff)
							begin
								prev_ff <= amp_ff;
								seg_ff <= seg_ff + 4'h1;
								st_ff <= last_ff ? S_NEXT : S_LOAD;
							end
						end
					S_WAIT:
						if (ms_p_ff)
						begin
							wait_ff <= wait_ff - 11'h001;
							if (wait_ff == 11'h001)
								st_ff <= S_NEXT; // [RQ23]
						end
					S_NEXT:
						if (rep_ff != 2'h0)
						begin
							rep_ff <= rep_ff - 2'h1; // [RQ11]
							st_ff <= S_ENTRY;
						end
						else if (slot_ff == 3'h7 || slot_nv == 8'h00)
						begin
							if (main_ff != 3'h0)
							begin
								main_ff <= main_ff - 3'h1; // [RQ12]
								slot_ff <= 3'h0;
								rep_ff <= loop_ff[1:0];
								st_ff <= S_ENTRY;
							end
							else
								st_ff <= S_IDLE; // [RQ22]
						end
						else
						begin
							slot_ff <= slot_n; // [RQ8]
							rep_ff <= loop_n;
							st_ff <= S_ENTRY;
						end
					S_RTP:
						if (mode != `HPS_M_RTP)
							st_ff <= S_IDLE; // [RQ14]
					S_EXT:
						if (proc_done)
							st_ff <= S_IDLE; // [RQ22]
					default: st_ff <= S_IDLE;
				endcase
		end
	end

	// Drive level before the gate; ramps follow the stretched time, waits are silent.
	always @*
	begin
		case (st_ff)
			S_SEG: raw_v = ramp_ff ? interp : amp_ff; // [RQ5]
			S_LOAD: raw_v = prev_ff;
			S_RTP: raw_v = rtp_ff[`HPS_RTPV]; // [RQ13]
			default: raw_v = 8'sh00; // [RQ23]
		endcase
		mag_v = raw_v[7] ? (8'h00 - raw_v) : raw_v;
		case (rtp_ff[`HPS_NG])
			2'h1: thr_v = `HPS_NG1;
			2'h2: thr_v = `HPS_NG2;
			2'h3: thr_v = `HPS_NG3;
			default: thr_v = 8'h00;
		endcase
	end

	// Registered drive amplitude after the noise gate.
	always @(posedge aclk)
	begin
		if (rst)
			drv_ff <= 8'h00;
		else
			drv_ff <= (mag_v < thr_v) ? 8'h00 : raw_v; // [RQ18]
	end

	assign lib_addr = {ctrl_ff[`HPS_LIB], id_ff, seg_ff}; // [RQ1]
	assign drive_amp = drv_ff;
	assign drive_en = (st_ff != S_IDLE) && (st_ff != S_EXT);
	assign drive_from_lib = drive_en && (st_ff != S_RTP); // [RQ2]
	assign drive_library_select_bit = ctrl_ff[`HPS_LIB];
	assign drive_open_loop = ctrl_ff[`HPS_OLOOP]; // [RQ15]
	assign drive_ol_period = rtp_ff[`HPS_OLP]; // [RQ15]
	assign proc_mode = mode;
	assign proc_start = pstart_ff;
	assign proc_abort = pabort_ff;
endmodule

// ### inc/hps_defs.vh
// Constants for the haptic playback sequencer: register offsets, field
// positions, reset values, mode codes and timing figures.
// Assumes the including file uses these names as plain text macros.
`ifndef HPS_DEFS_VH
`define HPS_DEFS_VH
// Register byte offsets on the AXI4-Lite bus.
`define HPS_A_CTRL 8'h00
`define HPS_A_STAT 8'h04
`define HPS_A_OFS 8'h08
`define HPS_A_SEQA 8'h0c
`define HPS_A_SEQB 8'h10
`define HPS_A_LOOP 8'h14
`define HPS_A_RTP 8'h18
// Control register fields.
`define HPS_GO 0
`define HPS_MODE 2:1
`define HPS_LIB 3
`define HPS_PBI 4
`define HPS_OLOOP 5
`define HPS_TRIGEN 6
// Loop register fields, real-time register fields.
`define HPS_MAIN 18:16
`define HPS_RTPV 7:0
`define HPS_NG 9:8
`define HPS_OLP 22:16
// Process modes.
`define HPS_M_SEQ 2'h0
`define HPS_M_RTP 2'h1
`define HPS_M_DIAG 2'h2
`define HPS_M_CAL 2'h3
// Reset values.
`define HPS_R_CTRL 32'h00000000
`define HPS_R_OFS 32'h00000000
`define HPS_R_SEQ 32'h00000000
`define HPS_R_LOOP 32'h00000000
`define HPS_R_RTP 32'h00000000
// Noise gate magnitude levels for codes 1 to 3; code 0 disables the gate.
`define HPS_NG1 8'h04
`define HPS_NG2 8'h08
`define HPS_NG3 8'h10
// Timing figures.
`define HPS_CLK_NS 4
`define HPS_T_MS_NS 1000000
// Cycles in one millisecond at the 4 ns clock, sized to fit the 18-bit counter.
`define HPS_MS_CYC 18'h3d090
`define HPS_T_TICK_MS 5
`define HPS_T_FINE_MS 1
`define HPS_T_WAIT_MS 10
`endif

// ### testbench/hps_pb_asserts.sv
// Checker for the playback sequencer: bus handshakes, library path, pulses.
// Assumes it is bound to hps_playback_seq and runs on its aclk and aresetn.
`timescale 1ns/1ps
`include "hps_defs.vh"
module hps_pb_asserts (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// Register bus.
	input wire awvalid,
	input wire awready,
	input wire wvalid,
	input wire wready,
	input wire [1:0] bresp,
	input wire bvalid,
	input wire bready,
	input wire arvalid,
	input wire arready,
	input wire [31:0] rdata,
	input wire [1:0] rresp,
	input wire rvalid,
	input wire rready,
	// Pins and drive side.
	input wire shutdown_pin_n,
	input wire [11:0] lib_addr,
	input wire [7:0] drive_amp,
	input wire drive_en,
	input wire drive_from_lib,
	input wire drive_library_select_bit,
	input wire [1:0] proc_mode,
	input wire proc_start,
	input wire proc_abort
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Answers hold still until taken, so a slow master loses nothing.
	bresp_hold_a:
	assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp moved");
	rdata_hold_a:
	assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata moved");
	write_answer_a:
	assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
		else $error("no bvalid");
	read_answer_a:
	assert property (arvalid && arready |=> rvalid) else $error("no rvalid");
	bus_block_a:
	assert property (bvalid |-> !awready && !wready) else $error("write taken early");
	slverr_zero_a:
	assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0) else $error("error data");
	// The library address always carries the selected library.
	library_select_bit_a:
	assert property (lib_addr[11] == drive_library_select_bit) else $error("library mismatch");
	lib_only_a:
	assert property (drive_from_lib |-> drive_en && proc_mode == `HPS_M_SEQ)
		else $error("library drive outside sequence");
	start_pulse_a:
	assert property (proc_start |-> proc_mode[1] ##1 !proc_start) else $error("bad start");
	// Once nothing plays, the registered amplitude must fall silent a cycle later.
	quiet_drive_a:
	assert property (!drive_en |=> drive_amp == 8'h00) else $error("drive while stopped");
	shutdown_a:
	assert property (!shutdown_pin_n [*4] |-> !drive_en && !bvalid && !rvalid)
		else $error("alive in shutdown");
	cover property (drive_from_lib);
	cover property (proc_start);
	cover property (rvalid && rresp == 2'h2);
	cover property (bvalid && !bready);
endmodule

// ### testbench/hps_drv_model.sv
// Drive core and effect library stand-in for the playback sequencer.
// Assumes the shared aclk; the library answers one cycle after its address.
`timescale 1ns/1ps
module hps_drv_model (
	// Clock.
	input wire aclk,
	// Library port.
	input wire [11:0] lib_addr,
	output reg [17:0] lib_data,
	// Drive core port.
	input wire drive_en,
	input wire proc_start,
	input wire proc_abort,
	output reg proc_done,
	input wire [7:0] vdd_val,
	output reg [7:0] vdd_sample,
	output reg vdd_strobe
);
	integer left = 0;
	integer dcyc = 0;
	initial
	begin
		lib_data = 18'h0;
		proc_done = 1'h0;
		vdd_sample = 8'h0;
		vdd_strobe = 1'h0;
	end
	// Every effect is a positive ramp of one tick, then a last negative step of one tick.
	always @(posedge aclk)
		lib_data <= lib_addr[3:0] != 4'h0 ? 18'h201c0 : 18'h10140;
	// Calibration and diagnostics end after 60 cycles unless aborted first.
	always @(posedge aclk)
	begin
		left <= proc_start === 1'b1 ? 60
			: (proc_abort === 1'b1 || left == 0 ? 0 : left - 1);
		proc_done <= left == 1;
	end
	// One supply reading per 32-cycle drive period; between readings the bus shows junk.
	always @(posedge aclk)
	begin
		dcyc <= dcyc + 1;
		vdd_strobe <= drive_en && dcyc[4:0] == 5'h0;
		vdd_sample <= drive_en && dcyc[4:0] == 5'h0 ? vdd_val : ~vdd_val;
	end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench: register bus, sequence timing, real-time path, pins.
// Assumes the design, the drive model and the checker are compiled first.
`timescale 1ns/1ps
`include "hps_defs.vh"
module tb_top;
	localparam [17:0] MSC = 18'h14;
	reg aclk = 1'h0, aresetn = 1'h0, shutdown_pin_n = 1'h1, trigger_interrupt_pin = 1'h0;
	reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	reg slow = 1'h0, dn;
	reg [7:0] awaddr = 8'h0, araddr = 8'h0, vdd_val = 8'h0;
	reg [31:0] wdata = 32'h0, lfsr = 32'h20, rd = 32'h0, x;
	reg [1:0] resp = 2'h0;
	wire awready, wready, bvalid, arready, rvalid, drive_en, drive_from_lib, drive_library_select_bit;
	wire drive_open_loop, proc_start, proc_abort, proc_done, vdd_strobe;
	wire [1:0] bresp, rresp, proc_mode;
	wire [31:0] rdata;
	wire [11:0] lib_addr;
	wire [17:0] lib_data;
	wire [7:0] drive_amp, vdd_sample;
	wire [6:0] drive_ol_period;
	integer num_errors = 0, n_compared = 0, cyc = 0, n_abort = 0, occ, i, j, t0, d, xe;
	hps_playback_seq #(.MS_CYC(MSC)) u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .shutdown_pin_n, .trigger_interrupt_pin,
		.lib_addr, .lib_data, .drive_amp, .drive_en, .drive_from_lib, .drive_library_select_bit,
		.drive_open_loop, .drive_ol_period, .proc_mode, .proc_start, .proc_abort, .proc_done,
		.vdd_sample, .vdd_strobe);
	hps_drv_model u_drv (.aclk, .lib_addr, .lib_data, .drive_en, .proc_start, .proc_abort,
		.proc_done, .vdd_val, .vdd_sample, .vdd_strobe);
	// Clock, a cycle count for timing sequences, and a tally of abort pulses.
	initial forever #2 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;
	always @(posedge aclk) n_abort <= n_abort + (proc_abort === 1'b1);
	function [31:0] rnd();
	begin
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		rnd = lfsr;
	end
	endfunction
	// Expected drive after the noise gate; small magnitudes are cut to zero.
	function [7:0] gate(input [7:0] a, input [1:0] c);
	reg [7:0] m;
	begin
		m = a[7] ? 8'h0 - a : a;
		gate = (c == 2'h1 && m < `HPS_NG1) || (c == 2'h2 && m < `HPS_NG2)
			|| (c == 2'h3 && m < `HPS_NG3) ? 8'h0 : a;
	end
	endfunction
	function integer tk(input integer o);
		tk = o > -1 ? o + 1 : 0;
	endfunction
	// Expected sequence length in cycles; occ counts played entries to size the slack.
	function integer seqc(input [63:0] s, input [31:0] lp, input pbi, input [31:0] o);
	integer m, k, r;
	begin
		seqc = 0;
		occ = 0;
		for (m = 0; m <= lp[18:16]; m = m + 1)
			for (k = 0; k < 8 && s[8*k +: 8] != 8'h0; k = k + 1)
			begin
				r = lp[2*k +: 2] + 1;
				occ = occ + r;
				seqc = seqc + r * MSC * (s[8*k+7] ? 10 * s[8*k +: 7]
					: (tk($signed(o[7:0])) + tk($signed(o[31:24]))) * (pbi ? 1 : 5));
			end
	end
	endfunction
	task chk(input [31:0] g, input [31:0] e);
	begin
		n_compared = n_compared + 1;
		if (g !== e)
		begin
			num_errors = num_errors + 1;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	end
	endtask
	task stop_test;
	begin
		$display("errors %0d, compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task hang;
	begin
		num_errors = num_errors + 1;
		stop_test;
	end
	endtask
	// Bus write; a slow master raises bready only after seeing bvalid.
	task wr(input [7:0] a, input [31:0] v);
	begin
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= !slow;
		dn = 1'h0;
		for (i = 0; i < 100 && !dn; i = i + 1)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
			if (bvalid && bready)
			begin
				resp = bresp;
				bready <= 1'h0;
				dn = 1'h1;
			end
			else if (bvalid)
				bready <= 1'h1;
		end
		if (!dn)
			hang;
		@(posedge aclk);
	end
	endtask
	task rdr(input [7:0] a);
	begin
		araddr <= a;
		arvalid <= 1'h1;
		rready <= !slow;
		dn = 1'h0;
		for (i = 0; i < 100 && !dn; i = i + 1)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'h0;
			if (rvalid && rready)
			begin
				rd = rdata;
				resp = rresp;
				rready <= 1'h0;
				dn = 1'h1;
			end
			else if (rvalid)
				rready <= 1'h1;
		end
		if (!dn)
			hang;
		@(posedge aclk);
	end
	endtask
	task rchk(input [7:0] a, input [31:0] e);
	begin
		rdr(a);
		chk(rd, e);
	end
	endtask
	// Launch by register; the start is registered, hence two edges of grace.
	task go(input [31:0] c);
	begin
		wr(`HPS_A_CTRL, c);
		t0 = cyc;
		repeat (2) @(posedge aclk);
	end
	endtask
	task idle;
	integer n;
	begin
		rd = 32'h10;
		for (n = 0; n < 4000 && rd[4]; n = n + 1)
			rdr(`HPS_A_STAT);
		if (rd[4])
			hang;
		d = cyc - t0;
	end
	endtask
	// A pin pulse of 40 ns high and 40 ns low.
	task pin;
	begin
		trigger_interrupt_pin <= 1'h1;
		repeat (10) @(posedge aclk);
		trigger_interrupt_pin <= 1'h0;
		repeat (10) @(posedge aclk);
	end
	endtask
	task run(input [31:0] o, input [63:0] s, input [31:0] lp, input pbi);
	begin
		wr(`HPS_A_OFS, o);
		wr(`HPS_A_SEQA, s[31:0]);
		wr(`HPS_A_SEQB, s[63:32]);
		wr(`HPS_A_LOOP, lp);
		xe = seqc(s, lp, pbi, o);
		go({27'h0, pbi, 4'h1});
		idle;
		chk(d > xe - 60 * occ - 40 && d < xe + 60 * occ + 40 ? xe : d, xe);
	end
	endtask
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (4) @(posedge aclk);
		for (j = 0; j < 7; j = j + 1)
			if (j != 1)
				rchk({j[5:0], 2'h0}, 32'h0);
		rdr(8'h1c);
		chk({resp, rd[29:0]}, 32'h80000000);
		wr(8'h1c, rnd());
		chk({30'h0, resp}, 32'h2);
		// Random offsets read back through a master that answers late.
		slow = 1'h1;
		for (j = 0; j < 4; j = j + 1)
		begin
			x = rnd();
			wr(`HPS_A_OFS, x);
			rchk(`HPS_A_OFS, x);
		end
		slow = 1'h0;
		run(32'h0, 64'h201, 32'h10000, 1'h0);
		run(32'hfe000002, 64'h38501, 32'h4, 1'h1);
		run(32'hff000000, 64'h7f060505_04030201, 32'h1, 1'h0);
		// Launch bit starts, a zero in it stops; the pin only counts when enabled.
		go(32'h1);
		rdr(`HPS_A_STAT);
		chk(rd[4], 1'h1);
		wr(`HPS_A_CTRL, 32'h0);
		rdr(`HPS_A_STAT);
		chk(rd[4], 1'h0);
		pin;
		rdr(`HPS_A_STAT);
		chk(rd[4], 1'h0);
		wr(`HPS_A_CTRL, 32'h40);
		pin;
		rdr(`HPS_A_STAT);
		chk(rd[4], 1'h1);
		pin;
		rdr(`HPS_A_STAT);
		chk(rd[4], 1'h0);
		// Real-time amplitudes through the gate, every gate code for both signs.
		go(32'h2b);
		chk({drive_library_select_bit, drive_open_loop}, 2'h3);
		for (j = 0; j < 12; j = j + 1)
		begin
			x = rnd();
			if (j < 8)
				x[9:0] = {j[1:0], j < 4 ? 8'h06 : 8'hfa};
			wr(`HPS_A_RTP, x);
			repeat (2) @(posedge aclk);
			chk(drive_amp, gate(x[7:0], x[9:8]));
			chk(drive_ol_period, x[22:16]);
		end
		vdd_val <= x[15:8];
		repeat (70) @(posedge aclk);
		rdr(`HPS_A_STAT);
		chk(rd[15:8], x[15:8]);
		wr(`HPS_A_CTRL, 32'h5);
		repeat (2) @(posedge aclk);
		chk(drive_en, 1'h0);
		wr(`HPS_A_CTRL, 32'h0);
		repeat (80) @(posedge aclk);
		// Diagnostics and calibration: end on completion, abort on a stop.
		for (j = 2; j < 4; j = j + 1)
		begin
			go({29'h0, j[1:0], 1'h1});
			idle;
			chk(d > 60 && d < 120, 1'h1);
			go({29'h0, j[1:0], 1'h1});
			x = n_abort;
			wr(`HPS_A_CTRL, {29'h0, j[1:0], 1'h0});
			repeat (2) @(posedge aclk);
			chk(n_abort - x, 32'h1);
		end
		// Shutdown wipes what was written.
		wr(`HPS_A_OFS, rnd());
		shutdown_pin_n <= 1'h0;
		repeat (4) @(posedge aclk);
		shutdown_pin_n <= 1'h1;
		repeat (4) @(posedge aclk);
		rchk(`HPS_A_OFS, 32'h0);
		stop_test;
	end
endmodule
bind hps_playback_seq hps_pb_asserts u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid,
	.wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
	.shutdown_pin_n, .lib_addr, .drive_amp, .drive_en, .drive_from_lib, .drive_library_select_bit,
	.proc_mode, .proc_start, .proc_abort);
